// ### bif_formatter.sv
// bcd input formatter: latches a peripheral sample by handshake and
// hands it to a host reader one ascii character (or byte) per request.
// assumes all inputs synchronous to core_clk; control writes are pulses.
`timescale 1ns/1ps
module bif_formatter
    import bif_pkg::*;
#(
    parameter int unsigned PRESET_LOW_CYCLES = PRESET_CYCLES
) (
    input  wire logic                core_clk,
    input  wire logic                rst_b,
    input  wire logic                ifReset,
    input  wire logic                ctl1Write,
    input  wire logic [7:0]          ctl1Data,
    input  wire logic                ctl2Write,
    input  wire logic [7:0]          ctl2Data,
    input  wire logic                ctl3Write,
    input  wire logic [7:0]          ctl3Data,
    input  wire logic                dataOutWrite,
    input  wire logic [7:0]          dataOutValue,
    input  wire logic                intEnableWrite,
    input  wire logic                intEnableValue,
    input  wire logic                charReq,
    input  wire logic [DIGITS_W-1:0] digitLines,
    input  wire logic                mantissaSignLine,
    input  wire logic                exponentSignLine,
    input  wire logic                overloadLine,
    input  wire logic                peripheralFlagA,
    output logic                     handshakeControlA,
    output logic                     peripheralReset_b,
    output logic [7:0]               dataOutReg,
    output logic                     intEnable,
    output logic                     irqRequest,
    output logic                     binaryMode,
    output logic [2:0]               status4,
    output logic                     charValid,
    output logic [7:0]               charData
);

    generate
        if (PRESET_LOW_CYCLES < 1 || PRESET_LOW_CYCLES >= (1 << PRESET_CNT_W)) begin : gBadCnt
            $error("peripheral reset low count out of range");
        end
    endgenerate

    localparam logic [PRESET_CNT_W-1:0] PRESET_LOAD = PRESET_CNT_W'(PRESET_LOW_CYCLES);

    // latched sample
    bif_sample_s sample;
    logic        latchLoad;
    logic [SAMPLE_W-1:0] sampleBits;

    bif_latch #(
        .WIDTH   (SAMPLE_W)
    ) uLatch (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .load     (latchLoad),
        .dataIn   ({digitLines, mantissaSignLine, exponentSignLine, overloadLine}),
        .dataOut  (sampleBits)
    );

    assign sample = bif_sample_s'(sampleBits);

    // handshake and interface control state
    bif_hs_e                 hsState_q;
    bif_hs_e                 hsState_d;
    logic                    handshake_control_a_q;
    logic                    handshake_control_a_d;
    logic                    irq_q;
    logic                    irq_d;
    logic                    intEn_q;
    logic                    intEn_d;
    logic [7:0]              dataOut_q;
    logic [7:0]              dataOut_d;
    logic                    binMode_q;
    logic                    binMode_d;
    logic [PRESET_CNT_W-1:0] presetCnt_q;
    logic [PRESET_CNT_W-1:0] presetCnt_d;
    logic                    presetB_q;
    logic                    presetB_d;
    logic                    flagAck;

    always_comb begin
        hsState_d   = hsState_q;
        handshake_control_a_d      = handshake_control_a_q;
        irq_d       = irq_q;
        intEn_d     = intEn_q;
        dataOut_d   = dataOut_q;
        binMode_d   = binMode_q;
        presetCnt_d = presetCnt_q;
        presetB_d   = presetB_q;
        latchLoad   = 1'b0;
        flagAck     = 1'b0;

        // busy-to-ready of the flag clocks the data in and drops control
        case (hsState_q)
            HS_IDLE: begin
                if (ctl2Write && ctl2Data != 8'h00) begin
                    hsState_d = HS_WAIT_BUSY;
                    handshake_control_a_d    = 1'b1;
                end
            end
            HS_WAIT_BUSY: begin
                if (peripheralFlagA) begin
                    hsState_d = HS_WAIT_READY;
                end
            end
            HS_WAIT_READY: begin
                if (!peripheralFlagA) begin
                    hsState_d = HS_IDLE;
                    handshake_control_a_d    = 1'b0;
                    latchLoad = 1'b1;
                    flagAck   = 1'b1;
                end
            end
            default: begin
                hsState_d = HS_IDLE;
                handshake_control_a_d    = 1'b0;
            end
        endcase

        // acknowledge sets irq and wins over a same-cycle request clear
        if (ctl2Write && ctl2Data != 8'h00) begin
            irq_d = 1'b0;
        end
        if (flagAck) begin
            irq_d = 1'b1;
        end

        if (intEnableWrite) begin
            intEn_d = intEnableValue;
        end
        if (dataOutWrite) begin
            dataOut_d = dataOutValue;
        end
        if (ctl3Write) begin
            binMode_d = (ctl3Data == 8'h01);
        end

        if (presetCnt_q != '0) begin
            presetCnt_d = presetCnt_q - PRESET_CNT_W'(1);
        end
        presetB_d = (presetCnt_d == '0);

        // interface reset overrides everything except the mode register
        if (ifReset) begin
            hsState_d   = HS_IDLE;
            handshake_control_a_d      = 1'b0;
            dataOut_d   = 8'h00;
            intEn_d     = 1'b0;
            irq_d       = 1'b1;
            latchLoad   = 1'b0;
            presetCnt_d = PRESET_LOAD;
            presetB_d   = 1'b0;
            // mode register left alone, so a same-cycle mode write still lands
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            hsState_q   <= HS_IDLE;
            handshake_control_a_q      <= 1'b0;
            irq_q       <= 1'b1;
            intEn_q     <= 1'b0;
            dataOut_q   <= 8'h00;
            binMode_q   <= 1'b0;
            presetCnt_q <= PRESET_LOAD;
            presetB_q   <= 1'b0;
        end else begin
            hsState_q   <= hsState_d;
            handshake_control_a_q      <= handshake_control_a_d;
            irq_q       <= irq_d;
            intEn_q     <= intEn_d;
            dataOut_q   <= dataOut_d;
            binMode_q   <= binMode_d;
            presetCnt_q <= presetCnt_d;
            presetB_q   <= presetB_d;
        end
    end

    // character stream
    function automatic logic [3:0] groupAt(input logic [DIGITS_W-1:0] d,
                                           input logic [3:0] idx);
        logic [3:0] g;
        g = 4'h0;
        for (int i = 0; i < NUM_GROUPS; i++) begin
            if (idx == 4'(i)) begin
                g = d[i*GROUP_W +: GROUP_W];
            end
        end
        return g;
    endfunction

    function automatic logic [7:0] digitChar(input logic [3:0] n);
        logic [7:0] c;
        c = ASC_LF;
        if (n <= NIB_NINE) begin
            c = ASC_ZERO + {4'h0, n};
        end else begin
            case (n)
                NIB_PLUS:  c = ASC_PLUS;
                NIB_COMMA: c = ASC_COMMA;
                NIB_MINUS: c = ASC_MINUS;
                NIB_E:     c = ASC_E;
                NIB_DOT:   c = ASC_DOT;
                default:   c = ASC_LF;
            endcase
        end
        return c;
    endfunction

    logic [3:0] ptr_q;
    logic [3:0] ptr_d;
    logic       fresh_q;
    logic       fresh_d;
    logic       charValid_q;
    logic       charValid_d;
    logic [7:0] charData_q;
    logic [7:0] charData_d;
    logic [3:0] ptrNow;
    logic       rewind;

    always_comb begin
        ptr_d       = ptr_q;
        fresh_d     = fresh_q;
        charValid_d = 1'b0;
        charData_d  = charData_q;
        // rewinding in the request's own cycle serves it from the start
        rewind = ifReset || (ctl1Write && ctl1Data != 8'h00) || ctl3Write;
        ptrNow = rewind ? POS_MSIGN : ptr_q;
        ptr_d  = ptrNow;

        if (charReq) begin
            charValid_d = 1'b1;
            if (binMode_d) begin
                if (!fresh_q || ptrNow >= POS_BIN_LF) begin
                    // stale data answers with a line-feed so the reader ends
                    charData_d = ASC_LF;
                    ptr_d      = POS_MSIGN;
                    fresh_d    = 1'b0;
                end else begin
                    charData_d = {groupAt(sample.digits, {ptrNow[2:0], 1'b0}),
                                  groupAt(sample.digits, {ptrNow[2:0], 1'b1})};
                    ptr_d      = ptrNow + 4'h1;
                end
            end else begin
                case (ptrNow)
                    POS_MSIGN:   charData_d = sample.mantissaSign ? ASC_MINUS : ASC_PLUS;
                    POS_EXP_E:   charData_d = ASC_E;
                    POS_ESIGN:   charData_d = sample.exponentSign ? ASC_MINUS : ASC_PLUS;
                    POS_EXP_DIG: charData_d = digitChar(groupAt(sample.digits, GRP_EXP));
                    POS_COMMA:   charData_d = ASC_COMMA;
                    POS_OVLD:    charData_d = sample.overload ? ASC_EIGHT : ASC_ZERO;
                    POS_FUNC:    charData_d = digitChar(groupAt(sample.digits, GRP_FUNC));
                    POS_LF:      charData_d = ASC_LF;
                    default:     charData_d = digitChar(groupAt(sample.digits,
                                                                ptrNow - 4'h1));
                endcase
                // a line-feed inside the digits does not rewind
                ptr_d = (ptrNow == POS_LF) ? POS_MSIGN : ptrNow + 4'h1;
            end
        end

        // a fresh latch wins over the clearing line-feed
        if (latchLoad) begin
            fresh_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ptr_q       <= POS_MSIGN;
            fresh_q     <= 1'b0;
            charValid_q <= 1'b0;
            charData_q  <= 8'h00;
        end else begin
            ptr_q       <= ptr_d;
            fresh_q     <= fresh_d;
            charValid_q <= charValid_d;
            charData_q  <= charData_d;
        end
    end

    // status register 4, the only path to signs and overload in binary mode
    logic [2:0] status4_q;
    logic [2:0] status4_d;

    always_comb begin
        status4_d            = 3'h0;
        status4_d[ST4_MSIGN] = sample.mantissaSign;
        status4_d[ST4_ESIGN] = sample.exponentSign;
        status4_d[ST4_OVLD]  = sample.overload;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            status4_q <= 3'h0;
        end else begin
            status4_q <= status4_d;
        end
    end

    assign handshakeControlA = handshake_control_a_q;
    assign peripheralReset_b = presetB_q;
    assign dataOutReg        = dataOut_q;
    assign intEnable         = intEn_q;
    assign irqRequest        = irq_q;
    assign binaryMode        = binMode_q;
    assign status4           = status4_q;
    assign charValid         = charValid_q;
    assign charData          = charData_q;

endmodule

// ### bif_formatter_assertions.sv
// port-level assertions for bif_formatter
// assumes a bind to the top instance; one clock domain
`timescale 1ns/1ps
module bif_formatter_assertions
    import bif_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       rst_b,
    input wire logic       ifReset,
    input wire logic       ctl1Write,
    input wire logic [7:0] ctl1Data,
    input wire logic       ctl2Write,
    input wire logic [7:0] ctl2Data,
    input wire logic       ctl3Write,
    input wire logic [7:0] ctl3Data,
    input wire logic       charReq,
    input wire logic       mantissaSignLine,
    input wire logic       exponentSignLine,
    input wire logic       overloadLine,
    input wire logic       peripheralFlagA,
    input wire logic       handshakeControlA,
    input wire logic [7:0] dataOutReg,
    input wire logic       intEnable,
    input wire logic       irqRequest,
    input wire logic       binaryMode,
    input wire logic [2:0] status4,
    input wire logic       charValid,
    input wire logic [7:0] charData
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // ack is the busy-to-ready edge while control is still set
    sequence ackSeen;
        handshakeControlA && !ifReset && $past(peripheralFlagA) && !peripheralFlagA;
    endsequence
    sequence latchedShows;
        ##1 status4 == {$past(mantissaSignLine, 2), $past(exponentSignLine, 2),
                        $past(overloadLine, 2)};
    endsequence
    a_ack_done: assert property (
        ackSeen |=> !handshakeControlA && irqRequest) else $error("ack did not end handshake");
    a_status_bits: assert property (
        ackSeen |=> latchedShows) else $error("status4 wrong after ack");
    a_hs_start: assert property (
        ctl2Write && ctl2Data != 8'h00 && !handshakeControlA && !ifReset
        |=> handshakeControlA && !irqRequest) else $error("handshake not started");
    a_irq_hold: assert property (
        irqRequest && !(ctl2Write && ctl2Data != 8'h00) |=> irqRequest)
        else $error("irq dropped");
    a_mode_select: assert property (
        ctl3Write |=> binaryMode == $past(ctl3Data == 8'h01)) else $error("mode not set");
    a_mode_kept: assert property (
        ifReset && !ctl3Write |=> $stable(binaryMode)) else $error("mode changed by reset");
    a_ifreset_clears: assert property (
        ifReset |=> !handshakeControlA && dataOutReg == 8'h00 && !intEnable && irqRequest)
        else $error("interface reset incomplete");
    a_char_pulse: assert property (
        charValid == $past(charReq)) else $error("charValid timing");
    a_rewind_sign: assert property (
        ctl1Write && ctl1Data != 8'h00 && charReq && !binaryMode && !ctl3Write
        && !handshakeControlA && !ifReset
        |=> charValid && charData == (status4[ST4_MSIGN] ? ASC_MINUS : ASC_PLUS))
        else $error("rewind not to sign");
endmodule

// ### bif_latch.sv
// holding register for one peripheral sample, read data registered
// assumes load is a single-cycle strobe in the core_clk domain
`timescale 1ns/1ps
module bif_latch
    import bif_pkg::*;
#(
    parameter int unsigned WIDTH = SAMPLE_W
) (
    input  wire logic             core_clk,
    input  wire logic             rst_b,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] dataIn,
    output logic      [WIDTH-1:0] dataOut
);

    logic [WIDTH-1:0] store_q;
    logic [WIDTH-1:0] store_d;

    generate
        if (WIDTH < 1) begin : gBadWidth
            $error("bif_latch width must be at least one");
        end
    endgenerate

    always_comb begin
        store_d = load ? dataIn : store_q;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            store_q <= '0;
        end else begin
            store_q <= store_d;
        end
    end

    assign dataOut = store_q;

endmodule

// ### bif_periph_model.sv
// behavioural peripheral on the handshake flag and data lines
// assumes busy-to-ready acknowledge; busy lasts busyCycles+1 cycles
`timescale 1ns/1ps
module bif_periph_model
    import bif_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        handshakeControlA,
    input  wire logic [3:0]  busyCycles,
    input  wire bif_sample_s sample,
    output bif_sample_s      lines,
    output logic             peripheralFlagA
);
    logic [1:0] st;
    logic [3:0] cnt;
    // lines churn while idle, hold while busy and invert after the ready cycle so a mistimed latch shows up
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= 2'h0;
            cnt <= 4'h0;
            peripheralFlagA <= 1'b0;
            lines <= '0;
        end else begin
            case (st)
                2'h0: begin
                    lines <= ~lines;
                    if (handshakeControlA) begin
                        st <= 2'h1;
                        cnt <= busyCycles;
                        peripheralFlagA <= 1'b1;
                    end
                end
                2'h1: begin
                    if (cnt == 4'h0) begin
                        st <= 2'h2;
                        lines <= sample;
                        peripheralFlagA <= 1'b0;
                    end
                    cnt <= cnt - 4'h1;
                end
                default: begin
                    lines <= ~sample;
                    if (!handshakeControlA) st <= 2'h0;
                end
            endcase
        end
    end
endmodule

// ### bif_pkg.sv
// constants, types and field layout shared by the formatter files
// assumes one 200 MHz clock and synchronous peripheral and host lines
// What this block does
// - standard order: sign, digits, E, sign, digit, comma, ovld, function, LF
// - overload position gives '8' if set, else '0'
// - character pointer kept between host requests
// - control register 1 non-zero write rewinds pointer
// - digit line-feed leaves pointer at next position
// - binary mode: bytes from two digit groups
// - each handshake latches five bytes, ten groups
// - binary line-feed after fifth byte; then new handshake
// - lower group upper nibble, weights 8421
// - all five bytes delivered before line-feed
// - binary adds only line-feed at sixth position
// - binary signs and overload only via status
// - control register 3 value 1 selects binary
// - status 4: bit2 mantissa, bit1 exponent, bit0 overload
// - interface reset: pulse, clears, irq set, mode kept
// - register 2 non-zero write starts handshake, clears irq
package bif_pkg;

    localparam int unsigned NUM_GROUPS = 10;
    localparam int unsigned GROUP_W    = 4;
    localparam int unsigned DIGITS_W   = NUM_GROUPS * GROUP_W;
    localparam int unsigned BIN_BYTES  = 5;

    // pointer positions in standard format
    localparam logic [3:0] POS_MSIGN    = 4'h0;
    localparam logic [3:0] POS_DIG_LAST = 4'h8;
    localparam logic [3:0] POS_EXP_E    = 4'h9;
    localparam logic [3:0] POS_ESIGN    = 4'ha;
    localparam logic [3:0] POS_EXP_DIG  = 4'hb;
    localparam logic [3:0] POS_COMMA    = 4'hc;
    localparam logic [3:0] POS_OVLD     = 4'hd;
    localparam logic [3:0] POS_FUNC     = 4'he;
    localparam logic [3:0] POS_LF       = 4'hf;
    // binary format: bytes 0..4, line-feed at 5
    localparam logic [3:0] POS_BIN_LF   = 4'h5;

    localparam logic [3:0] GRP_EXP  = 4'h8;
    localparam logic [3:0] GRP_FUNC = 4'h9;

    localparam logic [7:0] ASC_ZERO  = 8'h30;
    localparam logic [7:0] ASC_EIGHT = 8'h38;
    localparam logic [7:0] ASC_PLUS  = 8'h2b;
    localparam logic [7:0] ASC_MINUS = 8'h2d;
    localparam logic [7:0] ASC_COMMA = 8'h2c;
    localparam logic [7:0] ASC_E     = 8'h45;
    localparam logic [7:0] ASC_DOT   = 8'h2e;
    localparam logic [7:0] ASC_LF    = 8'h0a;
    localparam logic [3:0] NIB_NINE  = 4'h9;
    localparam logic [3:0] NIB_PLUS  = 4'ha;
    localparam logic [3:0] NIB_COMMA = 4'hb;
    localparam logic [3:0] NIB_MINUS = 4'hc;
    localparam logic [3:0] NIB_E     = 4'hd;
    localparam logic [3:0] NIB_DOT   = 4'he;

    // status register 4 bit positions
    localparam int unsigned ST4_MSIGN = 2;
    localparam int unsigned ST4_ESIGN = 1;
    localparam int unsigned ST4_OVLD  = 0;

    // peripheral reset low time
    localparam int unsigned CLK_PERIOD_PS  = 5000;
    localparam int unsigned PRESET_TIME_US = 15;
    localparam int unsigned PRESET_CYCLES  =
        (PRESET_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned PRESET_CNT_W   = 16;

    typedef struct packed {
        logic [DIGITS_W-1:0] digits;
        logic                mantissaSign;
        logic                exponentSign;
        logic                overload;
    } bif_sample_s;

    localparam int unsigned SAMPLE_W = DIGITS_W + 3;

    typedef enum logic [1:0] {
        HS_IDLE       = 2'b00,
        HS_WAIT_BUSY  = 2'b01,
        HS_WAIT_READY = 2'b10
    } bif_hs_e;

endpackage

// ### tb.sv
// self-checking bench for bif_formatter beside a peripheral model
// assumes bif_pkg, the design, bif_periph_model and the checker
`timescale 1ns/1ps
module tb;
    import bif_pkg::*;
    logic        core_clk, rst_b, ifReset, charReq, peripheralFlagA, charValid;
    logic        ctl1Write, ctl2Write, ctl3Write, dataOutWrite, intEnableWrite;
    logic        intEnableValue, handshakeControlA, peripheralReset_b;
    logic        intEnable, irqRequest, binaryMode;
    logic [7:0]  ctl1Data, ctl2Data, ctl3Data, dataOutValue, dataOutReg, charData;
    logic [2:0]  status4;
    logic [3:0]  busyCycles;
    bif_sample_s sample, lines, s;
    int          n_mismatch, checks, n;

    bif_formatter #(.PRESET_LOW_CYCLES(4)) dut (
        .core_clk, .rst_b, .ifReset, .ctl1Write, .ctl1Data, .ctl2Write, .ctl2Data,
        .ctl3Write, .ctl3Data, .dataOutWrite, .dataOutValue, .intEnableWrite,
        .intEnableValue, .charReq, .digitLines(lines.digits),
        .mantissaSignLine(lines.mantissaSign), .exponentSignLine(lines.exponentSign),
        .overloadLine(lines.overload), .peripheralFlagA, .handshakeControlA,
        .peripheralReset_b, .dataOutReg, .intEnable, .irqRequest, .binaryMode,
        .status4, .charValid, .charData);
    bif_periph_model model (.core_clk, .rst_b, .handshakeControlA, .busyCycles,
        .sample, .lines, .peripheralFlagA);

    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("mismatches %0d of %0d checks", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    function automatic logic [7:0] nibChar(input logic [3:0] v);
        case (v)
            NIB_PLUS: return ASC_PLUS;
            NIB_COMMA: return ASC_COMMA;
            NIB_MINUS: return ASC_MINUS;
            NIB_E: return ASC_E;
            NIB_DOT: return ASC_DOT;
            4'hf: return ASC_LF;
            default: return ASC_ZERO + {4'h0, v};
        endcase
    endfunction

    function automatic logic [7:0] expChar(input bif_sample_s v, input logic bin,
                                           input logic [3:0] p);
        if (bin) return (p == POS_BIN_LF) ? ASC_LF : {v.digits[8*p +: 4], v.digits[8*p+4 +: 4]};
        case (p)
            POS_MSIGN: return v.mantissaSign ? ASC_MINUS : ASC_PLUS;
            POS_EXP_E: return ASC_E;
            POS_ESIGN: return v.exponentSign ? ASC_MINUS : ASC_PLUS;
            POS_EXP_DIG: return nibChar(v.digits[4*GRP_EXP +: 4]);
            POS_COMMA: return ASC_COMMA;
            POS_OVLD: return v.overload ? ASC_EIGHT : ASC_ZERO;
            POS_FUNC: return nibChar(v.digits[4*GRP_FUNC +: 4]);
            POS_LF: return ASC_LF;
            default: return nibChar(v.digits[4*(p-1) +: 4]);
        endcase
    endfunction

    // back-to-back requests; the leading tick keeps charReq edges apart
    task automatic readChars(input bif_sample_s v, input logic bin, input logic [3:0] p,
                             input int cnt);
        tick();
        charReq = 1'b1;
        for (int i = 0; i < cnt; i++) begin
            tick();
            if (i == cnt - 1) charReq = 1'b0;
            chk("charValid", {7'h0, charValid}, 8'h01);
            chk("charData", charData, expChar(v, bin, p));
            p = p + 4'h1;
        end
    endtask

    task automatic ctlWr(input logic one, input logic [7:0] v, input logic rq);
        tick();
        ctl1Write = one;
        ctl3Write = !one;
        ctl1Data = v;
        ctl3Data = v;
        charReq = rq;
        tick();
        {ctl1Write, ctl3Write, charReq} = 3'h0;
    endtask

    task automatic handshake(input bif_sample_s v);
        tick();
        sample = v;
        busyCycles = 4'($urandom_range(0, 12));
        ctl2Write = 1'b1;
        ctl2Data = 8'($urandom_range(1, 255));
        tick();
        ctl2Write = 1'b0;
        chk("irqClear", {7'h0, irqRequest}, 8'h00);
        for (int i = 0; i < 60 && irqRequest !== 1'b1; i++) tick();
        if (irqRequest !== 1'b1) begin
            n_mismatch++;
            end_sim();
        end
        tick();
        chk("status4", {5'h0, status4}, {5'h0, v.mantissaSign, v.exponentSign, v.overload});
    endtask

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    initial begin
        {rst_b, ifReset, charReq, ctl1Write, ctl2Write, ctl3Write} = '0;
        {dataOutWrite, intEnableWrite, intEnableValue, busyCycles} = '0;
        {ctl1Data, ctl2Data, ctl3Data, dataOutValue} = '0;
        sample = '0;
        n_mismatch = 0;
        checks = 0;
        void'($urandom(38357));
        repeat (8) @(posedge core_clk);
        #1 rst_b = 1'b1;
        chk("irqAtReset", {7'h0, irqRequest}, 8'h01);
        repeat (8) tick();
        for (int k = 0; k < 6; k++) begin
            s = SAMPLE_W'({$urandom(), $urandom()});
            s.overload = k[0];
            handshake(s);
            readChars(s, 1'b0, POS_MSIGN, 13);
            repeat (3) tick();
            readChars(s, 1'b0, POS_OVLD, 19);
        end
        s.digits[31:28] = 4'hf;
        handshake(s);
        readChars(s, 1'b0, POS_MSIGN, 9);
        readChars(s, 1'b0, POS_EXP_E, 7);
        readChars(s, 1'b0, POS_MSIGN, 3);
        ctlWr(1'b1, 8'h00, 1'b0);
        readChars(s, 1'b0, 4'h3, 1);
        ctlWr(1'b1, 8'($urandom_range(1, 255)), 1'b1);
        chk("rewind", charData, expChar(s, 1'b0, POS_MSIGN));
        readChars(s, 1'b0, 4'h1, 15);
        ctlWr(1'b0, 8'h01, 1'b0);
        chk("binMode", {7'h0, binaryMode}, 8'h01);
        // standard-mode latch is still unread in binary, so it is delivered first
        readChars(s, 1'b1, 4'h0, 6);
        readChars(s, 1'b1, POS_BIN_LF, 1);
        for (int k = 0; k < 4; k++) begin
            s = SAMPLE_W'({$urandom(), $urandom()});
            if (k == 0) s.digits = '1;
            handshake(s);
            readChars(s, 1'b1, 4'h0, 6);
            readChars(s, 1'b1, POS_BIN_LF, 1);
        end
        {dataOutWrite, intEnableWrite, intEnableValue} = 3'h7;
        dataOutValue = 8'ha5;
        tick();
        {dataOutWrite, intEnableWrite} = 2'h0;
        chk("dataOut", dataOutReg, 8'ha5);
        chk("intEn", {7'h0, intEnable}, 8'h01);
        // interface reset lands mid-handshake
        ctl2Write = 1'b1;
        ctl2Data = 8'h01;
        tick();
        ctl2Write = 1'b0;
        tick();
        ifReset = 1'b1;
        tick();
        ifReset = 1'b0;
        chk("dataOutClr", dataOutReg, 8'h00);
        chk("ifState", {3'h0, handshakeControlA, peripheralReset_b, intEnable, irqRequest,
            binaryMode}, 8'h03);
        n = 0;
        for (int i = 0; i < 50 && peripheralReset_b !== 1'b1; i++) begin
            tick();
            n++;
        end
        // low for exactly the four cycles the dut is given
        chk("presetLow", 8'(n), 8'h04);
        if (n >= 50) end_sim();
        repeat (20) tick();
        ctlWr(1'b0, 8'h02, 1'b0);
        chk("stdMode", {7'h0, binaryMode}, 8'h00);
        readChars(s, 1'b0, POS_MSIGN, 2);
        tick();
        ifReset = 1'b1;
        tick();
        ifReset = 1'b0;
        readChars(s, 1'b0, POS_MSIGN, 1);
        end_sim();
    end
endmodule

bind bif_formatter bif_formatter_assertions chk_i (.core_clk, .rst_b, .ifReset, .ctl1Write,
    .ctl1Data, .ctl2Write, .ctl2Data, .ctl3Write, .ctl3Data, .charReq, .mantissaSignLine,
    .exponentSignLine, .overloadLine, .peripheralFlagA, .handshakeControlA, .dataOutReg,
    .intEnable, .irqRequest, .binaryMode, .status4, .charValid, .charData);
